/* File: fcp_pkg.sv */
package fcp_pkg;

  // Control word fields.
  localparam int CW_W          = 16;
  localparam int RC_HI         = 11;
  localparam int RC_LO         = 10;
  localparam int PC_HI         = 9;
  localparam int PC_LO         = 8;
  localparam int MASK_W        = 6;
  localparam int INFCTL_BIT    = 12;
  localparam logic [15:0] CW_KEEP = 16'h0F3F;

  // Pointer image fields.
  localparam int PTR_W         = 64;
  localparam int OPC_W         = 11;

  // Offsets inside the saved environment image.
  localparam logic [7:0] ENV32_IP_OFS = 8'h0C;
  localparam logic [7:0] ENV32_DP_OFS = 8'h14;
  localparam logic [7:0] ENV16_IP_OFS = 8'h06;
  localparam logic [7:0] ENV16_DP_OFS = 8'h0A;

  typedef enum logic [1:0] {
    FCP_RND_NEAREST = 2'h0,
    FCP_RND_DOWN    = 2'h1,
    FCP_RND_UP      = 2'h2,
    FCP_RND_CHOP    = 2'h3
  } fcp_round_t;

  typedef enum logic [1:0] {
    FCP_PREC_SINGLE   = 2'h0,
    FCP_PREC_RESERVED = 2'h1,
    FCP_PREC_DOUBLE   = 2'h2,
    FCP_PREC_EXTENDED = 2'h3
  } fcp_prec_t;

  // Control word access commands from the execution core.
  typedef enum logic [1:0] {
    FCP_CMD_NONE,
    FCP_CMD_LOAD_CW,
    FCP_CMD_STORE_CW,
    FCP_CMD_STORE_CW_NOWAIT
  } fcp_cw_cmd_t;

  // Environment access commands.
  typedef enum logic [2:0] {
    FCP_ENV_NONE,
    FCP_ENV_LOAD,
    FCP_ENV_RESTORE,
    FCP_ENV_STORE,
    FCP_ENV_STORE_NOWAIT,
    FCP_ENV_SAVE,
    FCP_ENV_SAVE_NOWAIT
  } fcp_env_cmd_t;

endpackage

/* File: fcp_ptr_fmt.sv */
`timescale 1ns/1ps
`default_nettype none

// Packs a captured address into the pointer image for one format and mode.
module fcp_ptr_fmt (
  input  wire logic        fmt32,
  input  wire logic        prot,
  input  wire logic        with_opc,
  input  wire logic [15:0] sel,
  input  wire logic [31:0] ofs,
  input  wire logic [10:0] opc,
  output logic      [63:0] image
);
  import fcp_pkg::*;

  logic [63:0] img_p32;
  logic [63:0] img_r32;
  logic [63:0] img_p16;
  logic [63:0] img_r16;
  logic [11:0] opc32;
  logic [11:0] mid16;

  // Unused and undefined fields are driven to zero so images compare cleanly.
  assign opc32   = with_opc ? {1'b0, opc} : 12'h000;
  assign mid16   = with_opc ? {1'b0, opc} : 12'h000;
  assign img_p32 = {16'h0000, sel, ofs};
  assign img_r32 = {3'h0, ofs[31:16], 1'b0, opc32, 16'h0000, ofs[15:0]};
  assign img_p16 = {32'h0000_0000, sel, ofs[15:0]};
  assign img_r16 = {32'h0000_0000, ofs[19:16], mid16, ofs[15:0]};
  assign image   = fmt32 ? (prot ? img_p32 : img_r32) : (prot ? img_p16 : img_r16);

endmodule

`default_nettype wire

/* File: fcp_top.sv */
// Behaviour
// - Bits 11-10 select the rounding mode.
// - Bits 9-8 select result precision; 01 reserved.
// - Bits 5-0 mask six exceptions, 1 masks.
// - Bit 12 unused; reserved bits undefined.
// - Control word reached only via its instructions.
// - Exception records faulting operand address.
// - Layout chosen by operand size and mode.
// - 32-bit protected: selector and 32-bit offset.
// - 32-bit real: address split, zero gaps.
// - 16-bit protected: selector high, offset low.
// - 16-bit real: address 19-16 at top.
// - Protected instruction pointer holds selector, offset.
// - 32-bit real instruction pointer address split.
// - Real layouts also store 11-bit opcode.
// - 16-bit real instruction pointer, bit 27 zero.
// - Pointers reached only by environment instructions.
// - Data pointer at 14h or Ah.
// - Instruction pointer at Ch or 6h.
`timescale 1ns/1ps
`default_nettype none

module fcp_top (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire fcp_pkg::fcp_cw_cmd_t  cw_cmd,
  input  wire logic [15:0]           cw_wdata,
  output logic      [15:0]           cw_rdata,
  output logic                       cw_rvalid,
  input  wire fcp_pkg::fcp_env_cmd_t env_cmd,
  input  wire logic                  env_fmt32,
  input  wire logic [63:0]           env_dp_wdata,
  input  wire logic [63:0]           env_ip_wdata,
  output logic      [63:0]           env_dp_rdata,
  output logic      [63:0]           env_ip_rdata,
  output logic      [7:0]            env_dp_ofs,
  output logic      [7:0]            env_ip_ofs,
  output logic                       env_rvalid,
  input  wire logic                  exc_event,
  input  wire logic                  exc_fmt32,
  input  wire logic                  exc_prot,
  input  wire logic [15:0]           exc_data_sel,
  input  wire logic [31:0]           exc_data_ofs,
  input  wire logic [15:0]           exc_code_sel,
  input  wire logic [31:0]           exc_code_ofs,
  input  wire logic [10:0]           exc_opcode,
  output var  fcp_pkg::fcp_round_t   rounding_select,
  output var  fcp_pkg::fcp_prec_t    precision_select,
  output logic      [5:0]            exc_mask
);
  import fcp_pkg::*;

  logic [15:0] float_control_word;
  logic [63:0] fault_operand_pointer;
  logic [63:0] fault_instruction_pointer;
  logic [63:0] dp_image;
  logic [63:0] ip_image;
  logic        cw_load;
  logic        cw_store;
  logic        env_write;
  logic        env_read;
  logic [15:0] next_cw;

  // Command decode; apart from exception capture, nothing else reaches the registers.
  assign cw_load   = (cw_cmd == FCP_CMD_LOAD_CW);
  assign cw_store  = (cw_cmd == FCP_CMD_STORE_CW) || (cw_cmd == FCP_CMD_STORE_CW_NOWAIT);
  assign env_write = (env_cmd == FCP_ENV_LOAD) || (env_cmd == FCP_ENV_RESTORE);
  assign env_read  = (env_cmd == FCP_ENV_STORE) || (env_cmd == FCP_ENV_STORE_NOWAIT)
                  || (env_cmd == FCP_ENV_SAVE) || (env_cmd == FCP_ENV_SAVE_NOWAIT);

  // Reserved bits and the inert infinity control are stored as zero.
  assign next_cw = cw_wdata & CW_KEEP;

  // Operand pointer packing in the selected layout.
  fcp_ptr_fmt u_dp_fmt (
    .fmt32    (exc_fmt32),
    .prot     (exc_prot),
    .with_opc (1'b0),
    .sel      (exc_data_sel),
    .ofs      (exc_data_ofs),
    .opc      (exc_opcode),
    .image    (dp_image)
  );

  // Instruction pointer packing, opcode only in real layouts.
  fcp_ptr_fmt u_ip_fmt (
    .fmt32    (exc_fmt32),
    .prot     (exc_prot),
    .with_opc (1'b1),
    .sel      (exc_code_sel),
    .ofs      (exc_code_ofs),
    .opc      (exc_opcode),
    .image    (ip_image)
  );

  // Control word register; contents are undefined after reset, cleared here.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      float_control_word <= 16'h0000;
    end else if (cw_load) begin
      float_control_word <= next_cw;
    end
  end

  // Fault pointers; an exception wins over a same-cycle environment load.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_operand_pointer     <= 64'h0000_0000_0000_0000;
      fault_instruction_pointer <= 64'h0000_0000_0000_0000;
    end else if (exc_event) begin
      fault_operand_pointer     <= dp_image;
      fault_instruction_pointer <= ip_image;
    end else if (env_write) begin
      fault_operand_pointer     <= env_dp_wdata;
      fault_instruction_pointer <= env_ip_wdata;
    end
  end

  // Mode outputs registered from the stored word.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rounding_select  <= FCP_RND_NEAREST;
      precision_select <= FCP_PREC_SINGLE;
      exc_mask         <= 6'h00;
    end else begin
      rounding_select  <= fcp_round_t'(float_control_word[RC_HI:RC_LO]);
      precision_select <= fcp_prec_t'(float_control_word[PC_HI:PC_LO]);
      exc_mask         <= float_control_word[MASK_W-1:0];
    end
  end

  // Store paths answer one cycle after the command.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cw_rdata     <= 16'h0000;
      cw_rvalid    <= 1'b0;
      env_dp_rdata <= 64'h0000_0000_0000_0000;
      env_ip_rdata <= 64'h0000_0000_0000_0000;
      env_dp_ofs   <= 8'h00;
      env_ip_ofs   <= 8'h00;
      env_rvalid   <= 1'b0;
    end else begin
      cw_rvalid  <= cw_store;
      env_rvalid <= env_read;
      if (cw_store) begin
        cw_rdata <= float_control_word;
      end
      if (env_read) begin
        env_dp_rdata <= fault_operand_pointer;
        env_ip_rdata <= fault_instruction_pointer;
        env_dp_ofs   <= env_fmt32 ? ENV32_DP_OFS : ENV16_DP_OFS;
        env_ip_ofs   <= env_fmt32 ? ENV32_IP_OFS : ENV16_IP_OFS;
      end
    end
  end

  // Checks that tie outputs back to their causes.
  property p_cw_store_echo;
    @(posedge clk) disable iff (!nrst)
      cw_load ##1 (cw_cmd == FCP_CMD_STORE_CW) |=> (cw_rdata == $past(next_cw, 2));
  endproperty
  a_cw_store_echo: assert property (p_cw_store_echo) else $error("stored word mismatch");

  property p_round;
    @(posedge clk) disable iff (!nrst)
      cw_load |-> ##2 (rounding_select == fcp_round_t'($past(cw_wdata[RC_HI:RC_LO], 2)));
  endproperty
  a_round: assert property (p_round) else $error("rounding select wrong");

  property p_prec;
    @(posedge clk) disable iff (!nrst)
      cw_load |-> ##2 (precision_select == fcp_prec_t'($past(cw_wdata[PC_HI:PC_LO], 2)));
  endproperty
  a_prec: assert property (p_prec) else $error("precision select wrong");

  property p_mask;
    @(posedge clk) disable iff (!nrst)
      cw_load |-> ##2 (exc_mask == $past(cw_wdata[5:0], 2));
  endproperty
  a_mask: assert property (p_mask) else $error("mask wrong");

  property p_reserved_zero;
    @(posedge clk) disable iff (!nrst)
      cw_store |=> (cw_rdata[15:13] == 3'h0) && (cw_rdata[7:6] == 2'h0) && !cw_rdata[INFCTL_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  sequence s_fault;
    exc_event ##0 exc_prot ##0 exc_fmt32;
  endsequence
  property p_dp32;
    @(posedge clk) disable iff (!nrst)
      s_fault |=> (fault_operand_pointer[31:0] == $past(exc_data_ofs))
               && (fault_operand_pointer[47:32] == $past(exc_data_sel));
  endproperty
  a_dp32: assert property (p_dp32) else $error("data pointer wrong");

  property p_r16_ip;
    @(posedge clk) disable iff (!nrst)
      (exc_event && !exc_prot && !exc_fmt32) |=>
        (fault_instruction_pointer[26:16] == $past(exc_opcode))
        && !fault_instruction_pointer[27]
        && (fault_instruction_pointer[31:28] == $past(exc_code_ofs[19:16]));
  endproperty
  a_r16_ip: assert property (p_r16_ip) else $error("16-bit real ip wrong");

  property p_r32_dp;
    @(posedge clk) disable iff (!nrst)
      (exc_event && !exc_prot && exc_fmt32) |=>
        (fault_operand_pointer[60:45] == $past(exc_data_ofs[31:16]))
        && (fault_operand_pointer[44:32] == 13'h0000);
  endproperty
  a_r32_dp: assert property (p_r32_dp) else $error("32-bit real dp wrong");

  property p_env_ofs;
    @(posedge clk) disable iff (!nrst)
      (env_read && env_fmt32) |=> env_rvalid && (env_dp_ofs == 8'h14) && (env_ip_ofs == 8'h0C);
  endproperty
  a_env_ofs: assert property (p_env_ofs) else $error("environment offsets wrong");

  // Store answers are single pulses, so a stuck valid would repeat a memory write.
  property p_cw_rvalid;
    @(posedge clk) disable iff (!nrst)
      cw_store |=> cw_rvalid;
  endproperty
  a_cw_rvalid: assert property (p_cw_rvalid) else $error("store answer missing");

  property p_cw_quiet;
    @(posedge clk) disable iff (!nrst)
      !cw_store |=> !cw_rvalid;
  endproperty
  a_cw_quiet: assert property (p_cw_quiet) else $error("spurious store answer");

  property p_cw_hold;
    @(posedge clk) disable iff (!nrst)
      !cw_load |=> $stable(float_control_word);
  endproperty
  a_cw_hold: assert property (p_cw_hold) else $error("control word changed");

  property p_infctl;
    @(posedge clk) disable iff (!nrst)
      cw_load |=> !float_control_word[INFCTL_BIT]
               && (float_control_word[7:6] == 2'h0);
  endproperty
  a_infctl: assert property (p_infctl) else $error("inert bits stored");

  // Mode outputs follow the stored word only; nothing else may disturb them.
  property p_mode_hold;
    @(posedge clk) disable iff (!nrst)
      $stable(float_control_word) |=> $stable(rounding_select)
        && $stable(precision_select) && $stable(exc_mask);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode outputs moved");

  property p_env_rvalid;
    @(posedge clk) disable iff (!nrst)
      env_read |=> env_rvalid;
  endproperty
  a_env_rvalid: assert property (p_env_rvalid) else $error("env answer missing");

  property p_env_ofs16;
    @(posedge clk) disable iff (!nrst)
      (env_read && !env_fmt32) |=> (env_dp_ofs == ENV16_DP_OFS)
                                 && (env_ip_ofs == ENV16_IP_OFS);
  endproperty
  a_env_ofs16: assert property (p_env_ofs16) else $error("16-bit offsets wrong");

  property p_env_rdata;
    @(posedge clk) disable iff (!nrst)
      env_read |=> (env_dp_rdata == $past(fault_operand_pointer))
                && (env_ip_rdata == $past(fault_instruction_pointer));
  endproperty
  a_env_rdata: assert property (p_env_rdata) else $error("env store data wrong");

  // Pointers keep the last fault until a fault or an environment load replaces them.
  property p_ptr_hold;
    @(posedge clk) disable iff (!nrst)
      (!exc_event && !env_write) |=> $stable(fault_operand_pointer)
                                   && $stable(fault_instruction_pointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointers changed");

  property p_env_load;
    @(posedge clk) disable iff (!nrst)
      (env_write && !exc_event) |=> (fault_operand_pointer == $past(env_dp_wdata))
                                 && (fault_instruction_pointer == $past(env_ip_wdata));
  endproperty
  a_env_load: assert property (p_env_load) else $error("env load lost");

  property p_exc_wins;
    @(posedge clk) disable iff (!nrst)
      (exc_event && env_write) |=> (fault_operand_pointer == $past(dp_image))
                                && (fault_instruction_pointer == $past(ip_image));
  endproperty
  a_exc_wins: assert property (p_exc_wins) else $error("fault lost to load");

  // Fault kinds by layout.
  sequence s_fault_p16;
    exc_event ##0 exc_prot ##0 !exc_fmt32;
  endsequence

  sequence s_fault_r32;
    exc_event ##0 !exc_prot ##0 exc_fmt32;
  endsequence

  sequence s_fault_r16;
    exc_event ##0 !exc_prot ##0 !exc_fmt32;
  endsequence

  property p_dp16;
    @(posedge clk) disable iff (!nrst)
      s_fault_p16 |=> (fault_operand_pointer[31:16] == $past(exc_data_sel))
                   && (fault_operand_pointer[15:0] == $past(exc_data_ofs[15:0]))
                   && (fault_operand_pointer[63:32] == 32'h0000_0000);
  endproperty
  a_dp16: assert property (p_dp16) else $error("16-bit prot dp wrong");

  property p_ip32;
    @(posedge clk) disable iff (!nrst)
      s_fault |=> (fault_instruction_pointer[31:0] == $past(exc_code_ofs))
               && (fault_instruction_pointer[47:32] == $past(exc_code_sel));
  endproperty
  a_ip32: assert property (p_ip32) else $error("32-bit prot ip wrong");

  property p_r32_ip;
    @(posedge clk) disable iff (!nrst)
      s_fault_r32 |=> (fault_instruction_pointer[60:45] == $past(exc_code_ofs[31:16]))
                   && (fault_instruction_pointer[63:61] == 3'h0)
                   && (fault_instruction_pointer[42:32] == $past(exc_opcode))
                   && (fault_instruction_pointer[15:0] == $past(exc_code_ofs[15:0]));
  endproperty
  a_r32_ip: assert property (p_r32_ip) else $error("32-bit real ip wrong");

  property p_r16_dp;
    @(posedge clk) disable iff (!nrst)
      s_fault_r16 |=> (fault_operand_pointer[31:28] == $past(exc_data_ofs[19:16]))
                   && (fault_operand_pointer[27:16] == 12'h000)
                   && (fault_operand_pointer[15:0] == $past(exc_data_ofs[15:0]));
  endproperty
  a_r16_dp: assert property (p_r16_dp) else $error("16-bit real dp wrong");

endmodule

`default_nettype wire

/* File: fcp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Execution core stand-in. The setters only place a request; the bench lets the
// sampling edge pass, then idle drops the strobes and inverts four of the data lines.
module fcp_core_model (
  input  wire logic                  clk,
  output var  fcp_pkg::fcp_cw_cmd_t  cw_cmd,
  output logic [15:0]                cw_wdata,
  output var  fcp_pkg::fcp_env_cmd_t env_cmd,
  output logic                       env_fmt32,
  output logic [63:0]                env_dp_wdata,
  output logic [63:0]                env_ip_wdata,
  output logic                       exc_event,
  output logic                       exc_fmt32,
  output logic                       exc_prot,
  output logic [15:0]                exc_data_sel,
  output logic [31:0]                exc_data_ofs,
  output logic [15:0]                exc_code_sel,
  output logic [31:0]                exc_code_ofs,
  output logic [10:0]                exc_opcode
);
  import fcp_pkg::*;

  // Quiet bus at time zero.
  initial begin
    {cw_wdata, env_fmt32, env_dp_wdata, env_ip_wdata, exc_event, exc_fmt32} = '0;
    {exc_prot, exc_data_sel, exc_data_ofs, exc_code_sel, exc_code_ofs, exc_opcode} = '0;
    cw_cmd = FCP_CMD_NONE;
    env_cmd = FCP_ENV_NONE;
  end

  task automatic cw(input fcp_cw_cmd_t c, input logic [15:0] w);
    cw_cmd <= c;
    cw_wdata <= w;
  endtask

  task automatic env(input fcp_env_cmd_t c, input logic f, input logic [63:0] dp, ip);
    env_cmd <= c;
    env_fmt32 <= f;
    env_dp_wdata <= dp;
    env_ip_wdata <= ip;
  endtask

  task automatic exc(input logic f, p, input logic [15:0] ds, cs,
                     input logic [31:0] d, c, input logic [10:0] op);
    {exc_event, exc_fmt32, exc_prot} <= {1'b1, f, p};
    {exc_data_sel, exc_data_ofs, exc_code_sel, exc_code_ofs} <= {ds, d, cs, c};
    exc_opcode <= op;
  endtask

  // Released cw_wdata, env_dp_wdata and both offset lines show the inverse so a stale value cannot pass as held.
  task automatic idle();
    cw_cmd <= FCP_CMD_NONE;
    env_cmd <= FCP_ENV_NONE;
    exc_event <= 1'b0;
    cw_wdata <= ~cw_wdata;
    env_dp_wdata <= ~env_dp_wdata;
    exc_data_ofs <= ~exc_data_ofs;
    exc_code_ofs <= ~exc_code_ofs;
  endtask
endmodule

`default_nettype wire

/* File: fcp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module fcp_top_tb;
  import fcp_pkg::*;
  logic         clk, nrst, cw_rvalid, env_rvalid, env_fmt32, exc_event, exc_fmt32, exc_prot;
  fcp_cw_cmd_t  cw_cmd;
  fcp_env_cmd_t env_cmd;
  fcp_round_t   rounding_select;
  fcp_prec_t    precision_select;
  logic [5:0]   exc_mask;
  logic [7:0]   env_dp_ofs, env_ip_ofs;
  logic [10:0]  exc_opcode;
  logic [15:0]  cw_wdata, cw_rdata, exc_data_sel, exc_code_sel;
  logic [31:0]  exc_data_ofs, exc_code_ofs;
  logic [63:0]  env_dp_wdata, env_ip_wdata, env_dp_rdata, env_ip_rdata;
  int           n_fail, check_count;
  localparam logic [31:0] D = 32'h8765_4321, C = 32'h1357_9BDF;
  localparam logic [15:0] DS = 16'hB00B, CS = 16'h4E71;
  localparam logic [10:0] OP = 11'h5A6;

  fcp_top uut (.*);
  fcp_core_model core (.*);

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Each code lands in both mode fields; the store follows the load back to back.
  task automatic t_cw();
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 16'hF0C0 | 16'(i << 10) | 16'(i << 8) | 16'(6'h15 ^ 6'(i));
      @(posedge clk);
      core.cw(FCP_CMD_LOAD_CW, w);
      @(posedge clk);
      core.cw(i[0] ? FCP_CMD_STORE_CW : FCP_CMD_STORE_CW_NOWAIT, 16'h0);
      @(posedge clk);
      core.idle();
      #1;
      `CHK(cw_rvalid, 1'b1)
      `CHK(cw_rdata, w & 16'h0F3F)
      `CHK(rounding_select, 2'(i))
      `CHK(precision_select, 2'(i))
      `CHK(exc_mask, 6'h15 ^ 6'(i))
      @(posedge clk) #1;
      `CHK(cw_rvalid, 1'b0)
    end
  endtask

  // One fault per layout, read back after one idle cycle by each store and save command.
  task automatic t_exc();
    logic [63:0] dp, ip;
    for (int i = 0; i < 4; i++) begin
      case (i)
        3: {dp, ip} = {16'h0, DS, D, 16'h0, CS, C};
        2: {dp, ip} = {3'h0, D[31:16], 29'h0, D[15:0], 3'h0, C[31:16], 2'h0, OP, 16'h0, C[15:0]};
        1: {dp, ip} = {32'h0, DS, D[15:0], 32'h0, CS, C[15:0]};
        default: {dp, ip} = {32'h0, D[19:16], 12'h0, D[15:0], 32'h0, C[19:16], 1'b0, OP, C[15:0]};
      endcase
      @(posedge clk);
      core.exc(i[1], i[0], DS, CS, D, C, OP);
      @(posedge clk);
      core.idle();
      @(posedge clk);
      core.env(fcp_env_cmd_t'(3 + i), i[1], 64'h0, 64'h0);
      @(posedge clk);
      core.idle();
      #1;
      `CHK(env_rvalid, 1'b1)
      `CHK(env_dp_rdata, dp)
      `CHK(env_ip_rdata, ip)
      `CHK(env_dp_ofs, i[1] ? 8'h14 : 8'h0A)
      `CHK(env_ip_ofs, i[1] ? 8'h0C : 8'h06)
    end
  endtask

  // Load, then a restore colliding with a fault, where the fault must win.
  task automatic t_load(input fcp_env_cmd_t c, input logic x, input logic [63:0] dp, ip);
    @(posedge clk);
    core.env(c, 1'b1, 64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210);
    if (x) core.exc(1'b1, 1'b1, DS, CS, D, C, OP);
    @(posedge clk);
    core.idle();
    @(posedge clk);
    core.env(FCP_ENV_STORE, 1'b1, 64'h0, 64'h0);
    @(posedge clk);
    core.idle();
    @(posedge clk) #1;
    `CHK(env_dp_rdata, dp)
    `CHK(env_ip_rdata, ip)
  endtask

  // Main sequence behind a 4-cycle reset.
  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_cw();
    t_exc();
    t_load(FCP_ENV_LOAD, 1'b0, 64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210);
    t_load(FCP_ENV_RESTORE, 1'b1, {16'h0, DS, D}, {16'h0, CS, C});
    complete_run();
  end

  // The tests need well under 200 cycles.
  initial begin
    #5000;
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire
